// ==== hdl/rsc_pkg.sv ====
// package of offsets, field positions and codes for the rx status block
package rsc_pkg;
  // ***********************************
  // register offsets
  // ***********************************
  localparam logic [7:0] RSC_OFS_COMM_STATUS = 8'h0b;
  localparam logic [7:0] RSC_OFS_RX_BIT_CONTROL = 8'h0c;
  localparam logic [7:0] RSC_OFS_RX_COLLISION_POSITION = 8'h0d;
  // ***********************************
  // field positions
  // ***********************************
  localparam int RSC_BIT_CIPHER = 5;
  localparam int RSC_BIT_KEEP = 7;
  localparam int RSC_BIT_COLL_FAULT = 3;
  localparam int RSC_BIT_INDEX_OK = 7;
  // ***********************************
  // reset values and collision index limit
  // ***********************************
  localparam logic [7:0] RSC_RST_BIT_CONTROL = 8'h00;
  localparam logic [6:0] RSC_MAX_INDEX = 7'h3f;
  // ***********************************
  // sequencer state codes
  // ***********************************
  typedef enum logic [2:0] {
    RSC_SEQ_IDLE = 3'h0,
    RSC_SEQ_PRE_TX = 3'h1,
    RSC_SEQ_TX = 3'h3,
    RSC_SEQ_PRE_RX = 3'h5,
    RSC_SEQ_WAIT_DATA = 3'h6,
    RSC_SEQ_RX = 3'h7
  } rsc_seq_t;
endpackage : rsc_pkg

// ==== hdl/rsc_regs.sv ====
// status, receive bit control and collision position registers
// Functional notes
// - bit 5 shows cipher; clear turns it off
// - only authentication sets cipher; writes cannot
// - read-only three-bit sequencer state code
// - bit 7 clear zeroes bits after collision
// - alignment 7: second bit to next byte
// - zero alignment byte mode, else bit mode
// - bit 3 makes collision raise integrity fault
// - last-bits counts valid bits, zero whole
// - last-bits cleared at start, loaded at end in bit mode only
// - index ok only for valid reportable collision
// - first collision index, first 8 bytes only
// - zero-based bit index across the frame
// - alignment added into collision index
// - collision sets flag and records position
// - parity or crc mismatch raises integrity fault
module rsc_regs
  import rsc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire logic [7:0] reg_addr, // register offset
  input wire logic reg_wr, // write strobe
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, registered
  input wire logic auth_ok, // card authenticate cmd succeeded
  input wire logic [2:0] seq_state, // sequencer state code in
  input wire logic rx_start, // reception starts
  input wire logic rx_bit_valid, // one received bit
  input wire logic rx_bit, // received bit value
  input wire logic rx_bit_coll, // collision on this bit
  input wire logic rx_parity_err, // parity or crc mismatch
  input wire logic rx_end, // end of communication
  output logic card_cipher_active, // cipher on for tx and rx
  output logic bit_oriented, // alignment nonzero
  output logic [7:0] rx_byte, // assembled byte
  output logic rx_byte_valid, // byte complete pulse
  output logic collision_seen_flag, // collision error flag
  output logic integrity_fault_flag // integrity error flag
);
  // ***********************************
  // control and status state
  // ***********************************
  logic keep_bits_past_collision; // keep values after collision
  logic [2:0] first_bit_offset; // receive alignment
  logic collision_as_integrity_fault; // collision -> integrity
  logic [2:0] final_byte_valid_count; // last-bits field
  logic collision_index_ok; // index valid
  logic [6:0] collision_index; // first collision index
  logic [7:0] bit_count; // bits placed since rx start
  logic [2:0] bit_pos; // next bit position in byte
  logic coll_in_frame; // a collision already passed
  logic [2:0] seq_code; // state code as shown

  // ***********************************
  // decode and combinational terms
  // ***********************************
  wire wr_status = reg_wr && reg_addr == RSC_OFS_COMM_STATUS;
  wire wr_ctrl = reg_wr && reg_addr == RSC_OFS_RX_BIT_CONTROL;
  // write of zero clears cipher, a one is ignored
  wire cipher_clear = wr_status && !reg_wdata[RSC_BIT_CIPHER];
  // bit mode when alignment nonzero
  assign bit_oriented = first_bit_offset != 3'h0;
  // zero bits after a collision unless keeping
  wire stored_bit = (coll_in_frame || rx_bit_coll)
      && !keep_bits_past_collision ? 1'b0 : rx_bit;
  // zero-based index across frame with alignment added
  wire [7:0] frame_pos = bit_count + {5'h00, first_bit_offset};
  // only first 8 bytes are reportable
  wire pos_ok = frame_pos <= {1'b0, RSC_MAX_INDEX};
  // only the first collision of a frame is recorded
  wire first_coll = rx_bit_valid && rx_bit_coll && !coll_in_frame;
  // byte completes when the top position is filled
  wire byte_done = rx_bit_valid && bit_pos == 3'h7;
  wire [2:0] next_bit_pos = bit_pos + 3'h1;
  // number of bits held in the unfinished byte
  wire [2:0] next_last_bits = bit_pos;
  // state code passes straight through so a read shows the
  // code of its own address cycle; unused 100b reads as idle
  assign seq_code = seq_state == 3'h4 ? RSC_SEQ_IDLE : seq_state;

  // ***********************************
  // read multiplexer
  // ***********************************
  wire [7:0] rd_status = {2'b00, card_cipher_active, 2'b00,
                          seq_code};
  wire [7:0] rd_ctrl = {keep_bits_past_collision, first_bit_offset,
                        collision_as_integrity_fault,
                        final_byte_valid_count};
  wire [7:0] rd_coll = {collision_index_ok, collision_index};
  wire [7:0] rd_mux = reg_addr == RSC_OFS_COMM_STATUS ? rd_status :
                      reg_addr == RSC_OFS_RX_BIT_CONTROL ? rd_ctrl :
                      reg_addr == RSC_OFS_RX_COLLISION_POSITION ?
                      rd_coll : 8'h00;

  // ***********************************
  // register read data
  // ***********************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= rd_mux;
    end
  end

  // ***********************************
  // cipher flag
  // ***********************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      card_cipher_active <= 1'b0;
    end else if (clk_en) begin
      if (auth_ok) begin
        card_cipher_active <= 1'b1;
      end else if (cipher_clear) begin
        card_cipher_active <= 1'b0;
      end
    end
  end

  // ***********************************
  // control bits written by software
  // ***********************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      keep_bits_past_collision <= RSC_RST_BIT_CONTROL[RSC_BIT_KEEP];
      first_bit_offset <= RSC_RST_BIT_CONTROL[6:4];
      collision_as_integrity_fault <= RSC_RST_BIT_CONTROL[RSC_BIT_COLL_FAULT];
    end else if (clk_en && wr_ctrl) begin
      keep_bits_past_collision <= reg_wdata[RSC_BIT_KEEP];
      first_bit_offset <= reg_wdata[6:4];
      collision_as_integrity_fault <= reg_wdata[RSC_BIT_COLL_FAULT];
    end
  end

  // ***********************************
  // last-bits field, decoder owned
  // ***********************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      final_byte_valid_count <= 3'h0;
    end else if (clk_en) begin
      if (rx_start) begin
        final_byte_valid_count <= 3'h0;
      end else if (rx_end && bit_oriented) begin
        final_byte_valid_count <= next_last_bits;
      end
    end
  end

  // ***********************************
  // bit assembly
  // ***********************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_count <= 8'h00;
      bit_pos <= 3'h0;
      rx_byte <= 8'h00;
      rx_byte_valid <= 1'b0;
      coll_in_frame <= 1'b0;
    end else if (clk_en) begin
      rx_byte_valid <= byte_done;
      if (rx_start) begin
        bit_count <= 8'h00;
        bit_pos <= first_bit_offset;
        rx_byte <= 8'h00;
        coll_in_frame <= 1'b0;
      end else if (rx_bit_valid) begin
        // count saturates so a long frame cannot wrap back
        // into the reportable index range when alignment is zero
        if (bit_count != 8'hff) begin
          bit_count <= bit_count + 8'h01;
        end
        rx_byte[bit_pos] <= stored_bit;
        bit_pos <= next_bit_pos;
        if (rx_bit_coll) begin
          coll_in_frame <= 1'b1;
        end
      end
    end
  end

  // ***********************************
  // collision position and error flags
  // ***********************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      collision_index_ok <= 1'b0;
      collision_index <= 7'h00;
      collision_seen_flag <= 1'b0;
      integrity_fault_flag <= 1'b0;
    end else if (clk_en) begin
      // flags and index restart at every rx_start; a bit that
      // comes with rx_start belongs to no frame and is dropped
      if (rx_start) begin
        collision_index_ok <= 1'b0;
        collision_index <= 7'h00;
        collision_seen_flag <= 1'b0;
        integrity_fault_flag <= 1'b0;
      end else begin
        if (first_coll) begin
          collision_seen_flag <= 1'b1;
          collision_index_ok <= pos_ok;
          collision_index <= pos_ok ? frame_pos[6:0] : 7'h00;
        end
        // reception continues after this flag
        if ((rx_bit_valid && rx_parity_err) ||
            (rx_bit_valid && rx_bit_coll &&
             collision_as_integrity_fault)) begin
          integrity_fault_flag <= 1'b1;
        end
      end
    end
  end
endmodule : rsc_regs

// ==== verif/rsc_regs_monitor.sv ====
// checker on the ports of the rx status register block
module rsc_regs_monitor
  import rsc_pkg::*;
(
  input wire logic clk, reset_n, clk_en, reg_wr, auth_ok,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_byte,
  input wire logic [2:0] seq_state,
  input wire logic rx_start, rx_bit_valid, rx_bit, rx_bit_coll, rx_end,
  input wire logic rx_parity_err, card_cipher_active, bit_oriented,
  input wire logic rx_byte_valid, collision_seen_flag, integrity_fault_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // read of the status register this cycle
  wire logic rd_stat = clk_en && reg_addr == RSC_OFS_COMM_STATUS;
  a_cipher_set: assert property (clk_en && auth_ok
    |=> card_cipher_active) else $error("cipher not set");
  a_cipher_hold: assert property (clk_en && !auth_ok
    && !card_cipher_active |=> !card_cipher_active)
    else $error("cipher set by write");
  a_cipher_off: assert property (rd_stat && reg_wr && !auth_ok
    && !reg_wdata[5] |=> !card_cipher_active) else $error("cipher kept");
  a_state_code: assert property (rd_stat |=> reg_rdata[2:0] ==
    (($past(seq_state) == 3'h4) ? 3'h0 : $past(seq_state)))
    else $error("state code wrong");
  a_status_rsvd: assert property (rd_stat |=> {reg_rdata[7:6],
    reg_rdata[4:3]} == 4'h0 && reg_rdata[5] == $past(card_cipher_active))
    else $error("status read wrong");
  a_bit_mode: assert property (clk_en
    && reg_addr == RSC_OFS_RX_BIT_CONTROL
    |=> (reg_rdata[6:4] != 3'h0) == $past(bit_oriented))
    else $error("bit mode wrong");
  a_coll_flag: assert property (clk_en && rx_bit_valid && rx_bit_coll
    && !rx_start |=> collision_seen_flag) else $error("no collision flag");
  a_parity_flag: assert property (clk_en && rx_bit_valid
    && rx_parity_err && !rx_start |=> integrity_fault_flag)
    else $error("no integrity flag");
  a_start_clear: assert property (clk_en && rx_start && !rx_bit_valid
    |=> !collision_seen_flag && !integrity_fault_flag)
    else $error("flags not cleared");
  a_freeze_hold: assert property (!clk_en |=> $stable(reg_rdata)
    && $stable(card_cipher_active) && $stable(collision_seen_flag)
    && $stable(integrity_fault_flag)) else $error("state moved while frozen");
endmodule : rsc_regs_monitor

// ==== verif/rsc_card_model.sv ====
// card side model feeding received bits to the block
module rsc_card_model (
  input wire logic clk, go,
  input wire logic [7:0] nbits, coll_at, perr_at,
  input wire logic [1:0] gap,
  output logic rx_start, rx_bit_valid, rx_bit, rx_bit_coll,
  output logic rx_parity_err, rx_end, busy
);
  timeunit 1ns;
  timeprecision 100ps;
  int i;
  // one frame per go pulse; gap idles between bits for a slow card
  initial begin
    {rx_start, rx_bit_valid, rx_bit, rx_bit_coll, rx_parity_err} = 5'h00;
    {rx_end, busy} = 2'h0;
    forever begin
      @(posedge clk iff go);
      #1 busy = 1'b1;
      rx_start = 1'b1;
      @(posedge clk);
      #1 rx_start = 1'b0;
      for (i = 0; i < nbits; i++) begin
        {rx_bit_valid, rx_bit} = 2'h3;
        rx_bit_coll = (i == coll_at);
        rx_parity_err = (i == perr_at);
        @(posedge clk);
        #1;
        // without a gap valid stays up from bit to bit
        if (gap != 2'h0) begin
          {rx_bit_valid, rx_bit_coll, rx_parity_err} = 3'h0;
          rx_bit = 1'b0; // released line shows the inverse
          repeat (gap) @(posedge clk);
          #1;
        end
      end
      {rx_bit_valid, rx_bit_coll, rx_parity_err} = 3'h0;
      rx_bit = 1'b0;
      rx_end = 1'b1;
      @(posedge clk);
      #1 {rx_end, busy} = 2'h0;
    end
  end
endmodule : rsc_card_model

// ==== verif/tb.sv ====
// self-checking bench of the rx status register block
module tb
  import rsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset_n, clk_en, reg_wr, auth_ok, rd_req, go, busy;
  logic rd_d = 1'b0; // a read was issued last cycle
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_byte, nbits, coll_at, perr_at;
  logic [2:0] seq_state;
  logic [1:0] gap;
  logic [31:0] r;
  logic [15:0] m;
  logic cca, bor, rbv, csf, iff_o, rs, rbvl, rb, rbc, rpe, re;
  logic [7:0] rq[$];
  logic [15:0] bq[$];
  int fail_count = 0, check_count = 0, seed = 6, i, k;
  rsc_regs dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .auth_ok(auth_ok), .seq_state(seq_state),
    .rx_start(rs), .rx_bit_valid(rbvl), .rx_bit(rb), .rx_bit_coll(rbc),
    .rx_parity_err(rpe), .rx_end(re), .card_cipher_active(cca),
    .bit_oriented(bor), .rx_byte(rx_byte), .rx_byte_valid(rbv),
    .collision_seen_flag(csf), .integrity_fault_flag(iff_o));
  rsc_card_model card (.clk(clk), .go(go), .nbits(nbits), .coll_at(coll_at),
    .perr_at(perr_at), .gap(gap), .rx_start(rs), .rx_bit_valid(rbvl),
    .rx_bit(rb), .rx_bit_coll(rbc), .rx_parity_err(rpe), .rx_end(re),
    .busy(busy));
  always #5 clk = ~clk;
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task wr(input logic [7:0] a, input logic [7:0] d);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge clk);
    #1 reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    {reg_addr, rd_req} = {a, 1'b1};
    rq.push_back(e);
    @(posedge clk);
    #1 rd_req = 1'b0;
    @(posedge clk);
    #1;
  endtask : rd
  task frame(input logic [7:0] n, c, p, input logic [1:0] g);
    {nbits, coll_at, perr_at, gap, go} = {n, c, p, g, 1'b1};
    @(posedge clk);
    #1 go = 1'b0;
    repeat (2) @(posedge clk);
    for (k = 0; k < 2000 && busy === 1'b1; k++) @(posedge clk);
    #1;
  endtask : frame
  // result watcher: oldest note against each read and each byte
  always @(posedge clk) begin
    if (rd_d) chk(reg_rdata, rq.pop_front());
    if (rbv === 1'b1) begin
      m = bq.pop_front();
      chk(rx_byte & m[15:8], m[7:0]);
    end
    rd_d <= rd_req;
  end
  initial begin
    #200000 fail_count++;
    finish_test();
  end
  initial begin
    {clk, reset_n, clk_en, reg_wr, auth_ok, rd_req, go} = 7'h10;
    {reg_addr, reg_wdata, seq_state} = 19'h0_0000;
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    rd(RSC_OFS_RX_BIT_CONTROL, RSC_RST_BIT_CONTROL);
    rd(8'h0e, 8'h00);
    for (i = 0; i < 8; i++) begin
      seq_state = i[2:0];
      rd(RSC_OFS_COMM_STATUS, (i == 4) ? 8'h00 : {5'h00, i[2:0]});
    end
    seq_state = 3'h0;
    r = $random(seed);
    wr(RSC_OFS_RX_BIT_CONTROL, r[7:0]);
    rd(RSC_OFS_RX_BIT_CONTROL, r[7:0] & 8'hf8);
    clk_en = 1'b0;
    wr(RSC_OFS_RX_BIT_CONTROL, ~r[7:0]);
    auth_ok = 1'b1;
    @(posedge clk);
    #1 {clk_en, auth_ok} = 2'h2;
    rd(RSC_OFS_RX_BIT_CONTROL, r[7:0] & 8'hf8);
    rd(RSC_OFS_COMM_STATUS, 8'h00);
    wr(RSC_OFS_COMM_STATUS, 8'hff);
    rd(RSC_OFS_COMM_STATUS, 8'h00);
    auth_ok = 1'b1;
    @(posedge clk);
    #1 auth_ok = 1'b0;
    rd(RSC_OFS_COMM_STATUS, 8'h20);
    wr(RSC_OFS_COMM_STATUS, 8'h00);
    rd(RSC_OFS_COMM_STATUS, 8'h00);
    wr(RSC_OFS_RX_COLLISION_POSITION, 8'hff);
    rd(RSC_OFS_RX_COLLISION_POSITION, 8'h00);
    wr(RSC_OFS_RX_BIT_CONTROL, 8'h48);
    bq.push_back(16'h7070);
    bq.push_back(16'hff00);
    frame(8'h0c, 8'h03, 8'hff, 2'h0);
    rd(RSC_OFS_RX_COLLISION_POSITION, 8'h87);
    rd(RSC_OFS_RX_BIT_CONTROL, 8'h48);
    chk({6'h00, csf, iff_o}, 8'h03);
    wr(RSC_OFS_RX_BIT_CONTROL, 8'h80);
    for (i = 0; i < 8; i++) bq.push_back(16'hffff);
    frame(8'h46, 8'h3f, 8'h0a, 2'h2);
    rd(RSC_OFS_RX_COLLISION_POSITION, 8'hbf);
    rd(RSC_OFS_RX_BIT_CONTROL, 8'h80);
    chk({7'h00, iff_o}, 8'h01);
    chk({7'h00, bor}, 8'h00);
    wr(RSC_OFS_RX_BIT_CONTROL, 8'h90);
    bq.push_back(16'hfefe);
    for (i = 0; i < 7; i++) bq.push_back(16'hffff);
    frame(8'h46, 8'h3f, 8'hff, 2'h0);
    rd(RSC_OFS_RX_COLLISION_POSITION, 8'h00);
    rd(RSC_OFS_RX_BIT_CONTROL, 8'h97);
    chk({6'h00, csf, iff_o}, 8'h02);
    chk({7'h00, bor}, 8'h01);
    wr(RSC_OFS_RX_BIT_CONTROL, 8'h00);
    rd(RSC_OFS_RX_BIT_CONTROL, 8'h07);
    bq.push_back(16'hffff);
    frame(8'h08, 8'hff, 8'hff, 2'h1);
    rd(RSC_OFS_RX_BIT_CONTROL, 8'h00);
    chk({6'h00, csf, iff_o}, 8'h00);
    finish_test();
  end
endmodule : tb
bind rsc_regs rsc_regs_monitor mon (.clk(clk), .reset_n(reset_n),
  .clk_en(clk_en), .reg_wr(reg_wr), .auth_ok(auth_ok), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_byte(rx_byte),
  .seq_state(seq_state), .rx_start(rx_start), .rx_bit_valid(rx_bit_valid),
  .rx_bit(rx_bit), .rx_bit_coll(rx_bit_coll), .rx_end(rx_end),
  .rx_parity_err(rx_parity_err), .card_cipher_active(card_cipher_active),
  .bit_oriented(bit_oriented), .rx_byte_valid(rx_byte_valid),
  .collision_seen_flag(collision_seen_flag),
  .integrity_fault_flag(integrity_fault_flag));
